// File: hw/ebos_ctrl.sv
// Ordinary-space bus controller for four external chip-select areas.
// Assumes a CPU-side request port and a plain local register port, one clock.
//
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/10ps
module ebos_ctrl #(
	parameter int N_AREA = 4,
	parameter int DATA_W = 16
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// CPU request port
	input wire logic cpu_req,
	input wire logic cpu_we,
	input wire logic [31:0] cpu_addr,
	input wire logic [1:0] cpu_be,
	input wire logic [15:0] cpu_wdata,
	output logic cpu_ready,
	output logic cpu_done,
	output logic [15:0] cpu_rdata,
	// Local register port
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// External memory bus
	output logic [ebos_pkg::EXT_ADDR_MSB:ebos_pkg::EXT_ADDR_LSB] ext_addr,
	output logic [3:0] area_select_n,
	output logic read_strobe_n,
	output logic upper_byte_write_strobe_n,
	output logic lower_byte_write_strobe_n,
	input wire logic [15:0] ext_data_in,
	output logic [15:0] ext_data_out,
	output logic ext_data_oe_n,
	input wire logic wait_req_n
);
	import ebos_pkg::*;

	// Only the documented geometry is served, refused at elaboration
	if (N_AREA != 4 || DATA_W != 16) begin : g_geometry_check
		$error("ebos_ctrl supports four areas of 16 bits only");
	end

	ebos_state_e state;
	ebos_state_e next_state;
	logic [15:0] idle_ctl;
	logic [15:0] wait_ctl;
	logic [1:0] iw [4];
	logic cw [4];
	logic sw [4];
	logic [1:0] wt [4];

	// Latched operation and history of the previous access
	logic [1:0] op_area;
	logic op_we;
	logic [1:0] op_be;
	logic op_ext;
	logic [1:0] op_wt;
	logic [1:0] wcnt;
	logic [1:0] gap_cnt;
	logic wait_smp;
	logic [1:0] last_area;
	logic last_read;
	logic last_valid;
	logic [1:0] idle_cnt;

	// State decode
	wire logic acc_any = (state == ST_LEAD) || (state == ST_T1) || (state == ST_TW)
		|| (state == ST_T2) || (state == ST_TRAIL);
	wire logic strobe_ph = (state == ST_T1) || (state == ST_TW) || (state == ST_T2);
	wire logic final_st = (state == ST_T2 && !op_ext) || (state == ST_TRAIL);

	// Per-area field split of both control registers
	genvar ga;
	generate
		for (ga = 0; ga < 4; ga++) begin : g_area
			assign iw[ga] = idle_ctl[IW_LSB + 2*ga +: 2];
			assign cw[ga] = idle_ctl[CW_LSB + ga];
			assign sw[ga] = idle_ctl[SW_LSB + ga];
			assign wt[ga] = wait_ctl[WT_STRIDE*ga +: 2];
			assign area_select_n[ga] = ~(acc_any && op_area == 2'(ga));
		end
	endgenerate

	// Request decode
	wire logic req_mapped = (cpu_addr[SPACE_MSB:SPACE_LSB] == 8'h00);
	wire logic [1:0] req_area = cpu_addr[AREA_MSB:AREA_LSB];
	// Ready depends on mapping so an unmapped answer never meets a bus answer
	assign cpu_ready = (state == ST_IDLE) || (final_st && req_mapped);
	wire logic accept = cpu_req && cpu_ready;
	wire logic launch = accept && req_mapped;

	// Previous access as seen from the current cycle
	wire logic [1:0] prev_area = final_st ? op_area : last_area;
	wire logic prev_read = final_st ? !op_we : last_read;
	wire logic prev_valid = final_st || last_valid;
	wire logic [2:0] have_sum = {1'b0, idle_cnt} + 3'h1;
	wire logic [1:0] have = final_st ? 2'h0 : (have_sum[2] ? IDLE_SAT : have_sum[1:0]);

	// Idle demand between the previous access and this one
	wire logic iw_apply = prev_valid && prev_read && (cpu_we || req_area != prev_area);
	wire logic [1:0] iw_need = iw_apply ? iw[prev_area] : 2'h0;
	wire logic cw_apply = prev_valid && req_area == prev_area && have == 2'h0;
	wire logic [1:0] cw_need = (cw_apply && cw[req_area]) ? 2'h1 : 2'h0;
	wire logic [1:0] need = (iw_need > cw_need) ? iw_need : cw_need;
	wire logic [1:0] shortfall = (need > have) ? 2'(need - have) : 2'h0;
	wire ebos_state_e req_start = sw[req_area] ? ST_LEAD : ST_T1;
	wire ebos_state_e op_start = op_ext ? ST_LEAD : ST_T1;
	wire ebos_state_e launch_st = (shortfall != 2'h0) ? ST_GAP : req_start;

	// Next state of the bus cycle
	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE: begin
				if (launch) begin
					next_state = launch_st;
				end
			end
			ST_GAP: begin
				if (gap_cnt == 2'h1) begin
					next_state = op_start;
				end
			end
			ST_LEAD: begin
				next_state = ST_T1;
			end
			ST_T1: begin
				next_state = (op_wt != 2'h0) ? ST_TW : ST_T2;
			end
			ST_TW: begin
				if (wcnt == 2'h1 && !wait_smp) begin
					next_state = ST_T2;
				end
			end
			ST_T2: begin
				if (op_ext) begin
					next_state = ST_TRAIL;
				end else if (launch) begin
					next_state = launch_st;
				end else begin
					next_state = ST_IDLE;
				end
			end
			ST_TRAIL: begin
				next_state = launch ? launch_st : ST_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Operation latch, taken when a request is launched
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			op_area <= 2'h0;
			op_we <= 1'b0;
			op_be <= 2'h0;
			op_ext <= 1'b0;
			op_wt <= 2'h0;
			ext_addr <= '0;
			ext_data_out <= 16'h0000;
		end else if (launch) begin
			op_area <= req_area;
			op_we <= cpu_we;
			op_be <= cpu_be;
			op_ext <= sw[req_area];
			op_wt <= wt[req_area];
			ext_addr <= cpu_addr[EXT_ADDR_MSB:EXT_ADDR_LSB];
			ext_data_out <= cpu_wdata;
		end
	end

	// Software wait counter; sampled request lags the pin by one edge
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wcnt <= 2'h0;
			wait_smp <= 1'b0;
		end else begin
			wait_smp <= !wait_req_n;
			if (state == ST_T1) begin
				wcnt <= op_wt;
			end else if (state == ST_TW && wcnt != 2'h1) begin
				wcnt <= wcnt - 2'h1;
			end
		end
	end

	// Gap counter for inserted idle cycles
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			gap_cnt <= 2'h0;
		end else if (launch) begin
			gap_cnt <= shortfall;
		end else if (state == ST_GAP) begin
			gap_cnt <= gap_cnt - 2'h1;
		end
	end

	// History: bus idle cycles since the last access and its kind
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			idle_cnt <= IDLE_SAT;
			last_area <= 2'h0;
			last_read <= 1'b0;
			last_valid <= 1'b0;
		end else if (final_st) begin
			idle_cnt <= 2'h0;
			last_area <= op_area;
			last_read <= !op_we;
			last_valid <= 1'b1;
		end else if (!acc_any && idle_cnt != IDLE_SAT) begin
			idle_cnt <= idle_cnt + 2'h1;
		end
	end

	// Read lanes kept only where the CPU asked for them
	wire logic [15:0] lane_mask = {{8{op_be[1]}}, {8{op_be[0]}}};

	// CPU answer, one cycle after the last strobe state or after an unmapped request is accepted
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cpu_done <= 1'b0;
			cpu_rdata <= 16'h0000;
		end else begin
			cpu_done <= (state == ST_T2) || (accept && !req_mapped);
			if (state == ST_T2 && !op_we) begin
				cpu_rdata <= ext_data_in & lane_mask;
			end else if (accept && !req_mapped) begin
				cpu_rdata <= 16'h0000;
			end
		end
	end

	// External strobes; no strobe in lead or trailing states
	assign read_strobe_n = ~(strobe_ph && !op_we);
	assign upper_byte_write_strobe_n = ~(strobe_ph && op_we && op_be[1]);
	assign lower_byte_write_strobe_n = ~(strobe_ph && op_we && op_be[0]);
	// Write data held into the trailing state for slow write hold
	assign ext_data_oe_n = ~(op_we && (strobe_ph || state == ST_TRAIL));

	// Register write decode
	wire logic wr_idle = reg_wr && reg_addr == OFS_IDLE_CTL;
	wire logic wr_wait = reg_wr && reg_addr == OFS_WAIT_CTL;
	wire logic [15:0] status_word = {11'h000, wait_smp, last_read, last_area, !(state == ST_IDLE)};

	// Control registers; reserved wait bits forced to one
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			idle_ctl <= RST_IDLE_CTL;
			wait_ctl <= RST_WAIT_CTL;
		end else begin
			if (wr_idle) begin
				idle_ctl <= reg_wdata;
			end
			if (wr_wait) begin
				wait_ctl <= reg_wdata | WAIT_RSV_MASK;
			end
		end
	end

	// Read data, valid the cycle after the read strobe only
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			unique case (reg_addr)
				OFS_IDLE_CTL: reg_rdata <= idle_ctl;
				OFS_WAIT_CTL: reg_rdata <= wait_ctl | WAIT_RSV_MASK;
				OFS_STATUS: reg_rdata <= status_word;
				default: reg_rdata <= 16'h0000;
			endcase
		end else begin
			reg_rdata <= 16'h0000;
		end
	end

endmodule // ebos_ctrl

// File: common/ebos_pkg.sv
// Constants, field layout and states of the ordinary-space bus controller.
// Assumes a 16-bit external data bus and four chip-select areas.
package ebos_pkg;
	// Register offsets on the local register port
	localparam logic [3:0] OFS_IDLE_CTL = 4'h0;
	localparam logic [3:0] OFS_WAIT_CTL = 4'h4;
	localparam logic [3:0] OFS_STATUS = 4'h8;
	// Reset values and reserved bits that read as one
	localparam logic [15:0] RST_IDLE_CTL = 16'hffff;
	localparam logic [15:0] RST_WAIT_CTL = 16'hffff;
	localparam logic [15:0] WAIT_RSV_MASK = 16'hcccc;
	// Field positions inside the two control registers
	localparam int IW_LSB = 8;
	localparam int CW_LSB = 4;
	localparam int SW_LSB = 0;
	localparam int WT_STRIDE = 4;
	// Address decode positions
	localparam int SPACE_MSB = 31;
	localparam int SPACE_LSB = 24;
	localparam int AREA_MSB = 23;
	localparam int AREA_LSB = 22;
	localparam int EXT_ADDR_MSB = 21;
	localparam int EXT_ADDR_LSB = 1;
	// Saturation of the bus idle counter
	localparam logic [1:0] IDLE_SAT = 2'h3;
	// Bus cycle states, one-hot
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_GAP = 7'h02,
		ST_LEAD = 7'h04,
		ST_T1 = 7'h08,
		ST_TW = 7'h10,
		ST_T2 = 7'h20,
		ST_TRAIL = 7'h40
	} ebos_state_e;
endpackage

// File: verif/ebos_mem_model.sv
// External memory model for the ordinary-space bus.
// Assumes 16 words indexed by low address bits; the bench sets the wait stretch.
`timescale 1ns/10ps
module ebos_mem_model (
	// Clock
	input wire logic ref_clk,
	// Bus from the controller
	input wire logic [ebos_pkg::EXT_ADDR_MSB:ebos_pkg::EXT_ADDR_LSB] ext_addr,
	input wire logic read_strobe_n,
	input wire logic upper_byte_write_strobe_n,
	input wire logic lower_byte_write_strobe_n,
	input wire logic [15:0] ext_data_out,
	// Bench control and answers
	input wire logic [1:0] stall,
	output logic [15:0] ext_data_in,
	output logic wait_req_n
);
	logic [15:0] mem [16];
	logic [15:0] last = 16'h0;
	logic [2:0] cnt = 3'h0;
	wire act = !read_strobe_n || !upper_byte_write_strobe_n || !lower_byte_write_strobe_n;
	// Inverse of last word once released, so a stale value never passes
	assign ext_data_in = !read_strobe_n ? mem[ext_addr[4:1]] : ~last;
	// Wait held low for the first stall cycles of each strobe run
	assign wait_req_n = !(act && cnt < {1'b0, stall});
	// Byte lanes written only under their own strobe
	always @(posedge ref_clk) begin
		cnt <= act ? cnt + 3'h1 : 3'h0;
		if (!read_strobe_n)
			last <= mem[ext_addr[4:1]];
		if (!upper_byte_write_strobe_n)
			mem[ext_addr[4:1]][15:8] <= ext_data_out[15:8];
		if (!lower_byte_write_strobe_n)
			mem[ext_addr[4:1]][7:0] <= ext_data_out[7:0];
	end
endmodule // ebos_mem_model

// File: verif/ebos_ctrl_properties.sv
// Port checker for the ordinary-space bus controller.
// Assumes it is bound onto the controller and sees only its ports.
`timescale 1ns/10ps
module ebos_ctrl_checker (
	// Clock, reset, CPU side
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic cpu_req,
	input wire logic cpu_ready,
	input wire logic cpu_done,
	// External bus
	input wire logic [3:0] area_select_n,
	input wire logic read_strobe_n,
	input wire logic upper_byte_write_strobe_n,
	input wire logic lower_byte_write_strobe_n,
	input wire logic [15:0] ext_data_out,
	input wire logic ext_data_oe_n
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// Either byte strobe active
	wire wr_any = !upper_byte_write_strobe_n || !lower_byte_write_strobe_n;
	one_select_a: assert property ($onehot0(~area_select_n)) else $error("two selects low");
	strobe_in_select_a: assert property ((!read_strobe_n || wr_any) |-> !(&area_select_n))
		else $error("strobe outside select");
	read_no_drive_a: assert property (!read_strobe_n |-> ext_data_oe_n && !wr_any)
		else $error("driving during read");
	write_drives_a: assert property (wr_any |-> !ext_data_oe_n) else $error("write not driven");
	read_two_states_a: assert property ($fell(read_strobe_n) |=> !read_strobe_n)
		else $error("read strobe too short");
	trail_data_held_a: assert property (!ext_data_oe_n && !wr_any && !(&area_select_n) |-> $stable(ext_data_out))
		else $error("write data dropped in trail");
	trail_drive_a: assert property ($past(wr_any) && !wr_any && read_strobe_n && $stable(area_select_n)
		&& !(&area_select_n) |-> !ext_data_oe_n) else $error("write data released in trail");
	read_answer_a: assert property ($rose(read_strobe_n) |-> cpu_done) else $error("read answer late");
	done_bound_a: assert property (cpu_req && cpu_ready |-> ##[1:20] cpu_done) else $error("no answer");
endmodule // ebos_ctrl_checker

// File: verif/ebos_ctrl_test.sv
// Self-checking bench for the ordinary-space bus controller.
// Assumes the memory model on the far side and the checker bound in.
`timescale 1ns/10ps
module ebos_ctrl_test;
	import ebos_pkg::*;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic cpu_req = 1'b0, cpu_we = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [31:0] cpu_addr = 32'h0;
	logic [1:0] cpu_be = 2'h3, stall = 2'h0;
	logic [15:0] cpu_wdata = 16'h0, reg_wdata = 16'h0, d;
	logic [3:0] reg_addr = 4'h0;
	logic cpu_ready, cpu_done, read_strobe_n, upper_byte_write_strobe_n, lower_byte_write_strobe_n;
	logic ext_data_oe_n, wait_req_n;
	logic [15:0] cpu_rdata, reg_rdata, ext_data_in, ext_data_out;
	logic [21:1] ext_addr;
	logic [3:0] area_select_n;
	logic ow [4];
	logic [31:0] oa [4];
	logic [1:0] ob [4];
	logic [15:0] od [4], rd [4];
	int fails = 0, check_count = 0, k;
	ebos_ctrl u_dut (.ref_clk, .rst_n, .cpu_req, .cpu_we, .cpu_addr, .cpu_be, .cpu_wdata, .cpu_ready, .cpu_done,
		.cpu_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ext_addr, .area_select_n, .read_strobe_n,
		.upper_byte_write_strobe_n, .lower_byte_write_strobe_n, .ext_data_in, .ext_data_out, .ext_data_oe_n, .wait_req_n);
	ebos_mem_model u_mem (.ref_clk, .ext_addr, .read_strobe_n, .upper_byte_write_strobe_n,
		.lower_byte_write_strobe_n, .ext_data_out, .stall, .ext_data_in, .wait_req_n);
	initial begin
		forever #10 ref_clk = ~ref_clk;
	end
	task automatic stop_test;
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Cycle counts belong to the bench, so plain ints are safe here
	task automatic chkn(input int got, input int exp);
		check_count++;
		if (got != exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	function automatic logic [15:0] lanes(logic [1:0] be, logic [15:0] n, logic [15:0] o);
		return {be[1] ? n[15:8] : o[15:8], be[0] ? n[7:0] : o[7:0]};
	endfunction
	task automatic wreg(input logic [3:0] a, input logic [15:0] v);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rreg(input logic [3:0] a, input logic [15:0] v);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(posedge ref_clk);
		chk(reg_rdata, v);
	endtask
	task automatic op(input int i, input logic w, input logic [1:0] ar, input logic [3:0] wd, input logic [1:0] be);
		ow[i] = w;
		oa[i] = {8'h00, ar, 17'h0, wd, 1'b0};
		ob[i] = be;
		od[i] = 16'($urandom);
	endtask
	task automatic put(input int i);
		cpu_we <= ow[i];
		cpu_addr <= oa[i];
		cpu_be <= ob[i];
		cpu_wdata <= od[i];
	endtask
	// Queued ops go back to back; e counts edges from the one presenting the first op to the one seeing the last answer
	task automatic run(input int n, input int e);
		int i, dn, t;
		i = 0;
		dn = 0;
		t = 1; // Presenting edge
		put(0);
		cpu_req <= 1'b1;
		while (dn < n && t < 60) begin
			@(posedge ref_clk);
			if (cpu_done === 1'b1) begin
				rd[dn] = cpu_rdata;
				dn++;
			end
			if (i > 0 || cpu_ready === 1'b1)
				t++;
			if (i < n && cpu_ready === 1'b1) begin
				i++;
				if (i < n)
					put(i);
				else
					cpu_req <= 1'b0;
			end
		end
		chkn(t, e);
	endtask
	task automatic pair(input logic [15:0] ic, input logic w0, input logic [1:0] a0, input logic w1,
		input logic [1:0] a1, input int e);
		wreg(OFS_IDLE_CTL, ic);
		op(0, w0, a0, 4'h1, 2'h3);
		op(1, w1, a1, 4'h2, 2'h3);
		run(2, e);
	endtask
	initial begin
		void'($urandom(32'h62fe67dc));
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		rreg(OFS_IDLE_CTL, RST_IDLE_CTL);
		rreg(OFS_WAIT_CTL, RST_WAIT_CTL);
		rreg(4'hc, 16'h0);
		wreg(OFS_WAIT_CTL, 16'h0);
		rreg(OFS_WAIT_CTL, WAIT_RSV_MASK);
		wreg(OFS_IDLE_CTL, 16'h0);
		// Full write, write with random byte enables, then a lane-masked read in each area
		for (int a = 0; a < 4; a++) begin
			op(0, 1'b1, 2'(a), 4'(a), 2'h3);
			op(1, 1'b1, 2'(a), 4'(a), 2'($urandom_range(3, 1)));
			op(2, 1'b0, 2'(a), 4'(a), 2'($urandom_range(3, 1)));
			run(3, 9);
			chk(rd[2], lanes(ob[2], lanes(ob[1], od[1], od[0]), 16'h0));
		end
		oa[0] = 32'h0100_0000;
		run(1, 3);
		chk(rd[0], 16'h0);
		// Every area0 wait code against a random wait stretch
		for (int w = 0; w < 4; w++) begin
			k = $urandom_range(3);
			wreg(OFS_WAIT_CTL, 16'(w));
			stall <= 2'(k);
			op(0, 1'b1, 2'h0, 4'h5, 2'h3);
			run(1, 5 + w + ((w > 0 && k >= w) ? k - w + 1 : 0));
		end
		stall <= 2'h0;
		wreg(OFS_WAIT_CTL, 16'h0);
		pair(16'h0000, 1'b1, 2'h0, 1'b1, 2'h0, 7);
		pair(16'h0010, 1'b1, 2'h0, 1'b1, 2'h0, 8);
		pair(16'h0210, 1'b0, 2'h0, 1'b1, 2'h0, 9);
		pair(16'h0300, 1'b0, 2'h0, 1'b0, 2'h1, 10);
		pair(16'h0100, 1'b0, 2'h0, 1'b0, 2'h0, 7);
		wreg(OFS_IDLE_CTL, 16'h0010);
		run(1, 5);
		wreg(OFS_IDLE_CTL, 16'h0310);
		op(0, 1'b0, 2'h0, 4'h1, 2'h3);
		run(1, 5);
		op(0, 1'b1, 2'h0, 4'h1, 2'h3);
		run(1, 6);
		wreg(OFS_IDLE_CTL, 16'h0001);
		run(1, 6);
		d = od[0];
		op(0, 1'b0, 2'h0, 4'h1, 2'h3);
		run(1, 6);
		chk(rd[0], d);
		rreg(OFS_STATUS, 16'h0008);
		stop_test;
	end
	// Hang guard well beyond the fewer than two hundred cycles the tests need
	initial begin
		repeat (5000) @(posedge ref_clk);
		fails++;
		stop_test;
	end
endmodule // ebos_ctrl_test
bind ebos_ctrl ebos_ctrl_checker u_chk (.ref_clk, .rst_n, .cpu_req, .cpu_ready, .cpu_done, .area_select_n,
	.read_strobe_n, .upper_byte_write_strobe_n, .lower_byte_write_strobe_n, .ext_data_out, .ext_data_oe_n);
